// ==== src/usb_uart_pkg.sv ====
// Purpose: shared constants and carrier types for the usb serial uart core
// Assumes: one 50 MHz system clock, synchronous active-low reset
// Notes:   timing counts are derived from the clock rate below
`default_nettype none

package usb_uart_pkg;

	// clock and timing
	localparam int unsigned REF_HZ          = 50_000_000;
	localparam int unsigned MS_CYCLES       = REF_HZ / 1000;
	localparam int unsigned RST_HOLD_MS     = 5;
	localparam int unsigned RST_HOLD_CYCLES = RST_HOLD_MS * MS_CYCLES;
	localparam int unsigned MAX_TIMEOUT_MS  = 255;

	// baud generation; periods in eighths of a reference tick, bit positions in x16 ticks
	localparam logic [16:0] EIGHTHS_PER_TICK = 17'h00008;
	localparam logic [16:0] PERIOD_DIV0      = 17'h00008;
	localparam logic [16:0] PERIOD_DIV1      = 17'h0000c;
	localparam logic [3:0]  HALF_BIT_TICK    = 4'h7;
	localparam logic [3:0]  LAST_BIT_TICK    = 4'hf;

	// buffers and flow control
	localparam int unsigned TX_DEPTH_DEF = 128;
	localparam int unsigned RX_DEPTH_DEF = 384;
	localparam int unsigned RX_STOP_ROOM = 32;
	localparam logic [7:0]  XON_CHAR     = 8'h11;
	localparam logic [7:0]  XOFF_CHAR    = 8'h13;

	// reset values of line outputs
	localparam logic TXD_IDLE = 1'b1;
	localparam logic LINE_OFF_N = 1'b1;

	typedef enum logic [1:0] {
		FLOW_NONE     = 2'b00,
		FLOW_RTS_CTS  = 2'b01,
		FLOW_DTR_DSR  = 2'b10,
		FLOW_XON_XOFF = 2'b11
	} flow_type;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_LEAD  = 3'b001,
		TX_START = 3'b010,
		TX_DATA  = 3'b011,
		TX_STOP  = 3'b100
	} tx_state_type;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_STOP  = 3'b011,
		RX_WAIT  = 3'b100
	} rx_state_type;

	typedef struct packed {
		logic [13:0] prescale;
		logic [2:0]  frac;
		logic        eight_bits;
		flow_type    flow;
		logic [7:0]  timeout_ms;
		logic        send_break;
		logic        rts_n;
		logic        dtr_n;
	} cfg_type;

	typedef struct packed {
		logic cts_n;
		logic dsr_n;
		logic dcd_n;
		logic ri_n;
	} modem_type;

	typedef struct packed {
		logic       brk;
		logic [7:0] data;
	} rx_word_type;

endpackage : usb_uart_pkg

`default_nettype wire

// ==== src/usb_serial_uart_core.sv ====
// Purpose: serial side of a usb bridge: baud generator, uart, buffers, reset output
// Assumes: all inputs synchronous to ref_clk_i; ref_tick_i marks one 48 MHz reference step
// Notes:   8N1 or 7N1 frames; the bridge's byte streams face the usb endpoint logic
`default_nettype none

// Operation
// (R1) baud generator makes sixteen-times bit clock
// (R2) divisor is 14-bit integer plus three fraction bits
// (R3) bit rate spans 183 baud to 3M
// (R4) seven or eight data bit frames
// (R5) rts cts dtr dsr dcd ri provided
// (R6) driver enable follows transmission for rs485
// (R7) selectable hardware or xon/xoff flow control
// (R8) send break on command, detect received break
// (R9) 128-byte transmit buffer feeds transmitter
// (R10) 384-byte receive buffer holds received bytes
// (R11) controller moves bytes between buffers and uart
// (R12) reference steps come from clock multiplier
// (R13) reset output low during reset
// (R14) reset output low 5 ms after conditions
// (R15) external reset held inactive unless used
// (R16) fraction selects eighths from 0 to 0.875
// (R17) prescale 1 gives 2M, 0 gives 3M
// (R18) receive flush timeout 1 to 255 ms
// (R19) driver enable asserted while sending break
// (R20) enable leads first start, trails last stop
// (R21) break latched and reported until read
module usb_serial_uart_core
	import usb_uart_pkg::*;
#(
	parameter int unsigned TX_DEPTH  = TX_DEPTH_DEF,
	parameter int unsigned RX_DEPTH  = RX_DEPTH_DEF,
	parameter int unsigned MS_CYC    = MS_CYCLES,
	parameter int unsigned RST_HOLD  = RST_HOLD_CYCLES
) (
	// clock, reset, enable
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        ce_i,
	input  wire logic        ref_tick_i,
	// reset generator
	input  wire logic        supply_ok_i,
	input  wire logic        osc_running_i,
	output logic             reset_output_n_o,
	// configuration
	input  wire cfg_type     cfg_i,
	// transmit byte stream from usb out endpoint
	input  wire logic        tx_valid_i,
	input  wire logic [7:0]  tx_data_i,
	output logic             tx_ready_o,
	// receive byte stream to usb in endpoint
	input  wire logic        rx_ready_i,
	output logic             rx_valid_o,
	output rx_word_type      rx_word_o,
	output logic             rx_flush_o,
	// serial line and modem lines
	output logic             txd_o,
	input  wire logic        rxd_i,
	output logic             tx_driver_enable_o,
	output logic             rts_n_o,
	output logic             dtr_n_o,
	input  wire modem_type   modem_i,
	output modem_type        modem_status_o
);

	localparam int TXW = $clog2(TX_DEPTH);
	localparam int TXC = $clog2(TX_DEPTH + 1);
	localparam int RXW = $clog2(RX_DEPTH);
	localparam int RXC = $clog2(RX_DEPTH + 1);
	localparam int MSW = $clog2(MS_CYC);
	localparam int RSW = $clog2(RST_HOLD + 1);

	typedef struct packed {
		logic [16:0]    acc;
		tx_state_type   tx_st;
		logic [3:0]     tx_tick;
		logic [2:0]     tx_bit;
		logic [7:0]     tx_shift;
		logic           txd;
		logic           de;
		logic           xoff;
		logic [TXW-1:0] tx_rd;
		logic [TXW-1:0] tx_wr;
		logic [TXC-1:0] tx_cnt;
		logic           tx_rdy;
		rx_state_type   rx_st;
		logic [3:0]     rx_tick;
		logic [2:0]     rx_bit;
		logic [7:0]     rx_shift;
		logic [RXW-1:0] rx_rd;
		logic [RXW-1:0] rx_wr;
		logic [RXC-1:0] rx_cnt;
		logic           out_valid;
		rx_word_type    out_word;
		logic           brk_flag;
		logic [MSW-1:0] ms_cnt;
		logic [7:0]     idle_ms;
		logic           flush;
		logic           rts_n;
		logic           dtr_n;
		modem_type      modem;
		logic [RSW-1:0] rst_cnt;
		logic           rst_out_n;
	} state_type;

	localparam state_type STATE_RESET = '{
		tx_st: TX_IDLE, rx_st: RX_IDLE, txd: TXD_IDLE, rts_n: LINE_OFF_N,
		dtr_n: LINE_OFF_N, modem: '1, default: '0};

	state_type   st;
	state_type   next_st;
	logic [7:0]  tx_mem [TX_DEPTH];
	logic [7:0]  rx_mem [RX_DEPTH];
	logic        tx_push;
	logic        rx_push;
	logic [7:0]  rx_byte;

	// divider period in eighths of a reference step; 0 and 1 ignore the fraction
	function automatic logic [16:0] period_eighths(input cfg_type c);
		if (c.prescale == 14'h0000) begin
			return PERIOD_DIV0; // R17
		end else if (c.prescale == 14'h0001) begin
			return PERIOD_DIV1; // R17
		end
		return {c.prescale, c.frac}; // R2 R16
	endfunction : period_eighths

	function automatic logic [RXW-1:0] rx_next(input logic [RXW-1:0] p);
		return (p == RXW'(RX_DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : rx_next

	// all control state advances here; memories are written in their own process
	always_comb begin
		logic        tick16;
		logic        pause;
		logic        can_send;
		logic        tx_pop;
		logic        rx_pop;
		logic [7:0]  word;
		logic [16:0] sum;
		logic        brk_set;
		next_st  = st;
		pause    = 1'b0;
		can_send = 1'b0;
		sum      = '0;
		brk_set  = 1'b0;
		tick16   = 1'b0;
		tx_pop   = 1'b0;
		rx_pop   = 1'b0;
		rx_push  = 1'b0;
		word     = '0;
		next_st.flush = 1'b0;

		// fractional divider: one x16 tick per period of eighths
		sum = st.acc + EIGHTHS_PER_TICK;
		if (ref_tick_i) begin // R12
			if (sum >= period_eighths(cfg_i)) begin
				next_st.acc = sum - period_eighths(cfg_i); // R1 R3
				tick16      = 1'b1;
			end else begin
				next_st.acc = sum;
			end
		end

		// transmit flow gate
		case (cfg_i.flow)
			FLOW_RTS_CTS:  pause = modem_i.cts_n; // R7
			FLOW_DTR_DSR:  pause = modem_i.dsr_n; // R7
			FLOW_XON_XOFF: pause = st.xoff; // R7
			default:       pause = 1'b0;
		endcase
		can_send = (st.tx_cnt != '0) && !pause && !cfg_i.send_break;
		tx_push  = tx_valid_i && st.tx_rdy; // R9

		// transmitter; enable leads by one bit and drops after the last stop bit
		if (tick16) begin
			next_st.tx_tick = st.tx_tick + 1'b1;
			case (st.tx_st)
				TX_IDLE: begin
					next_st.tx_tick = '0;
					next_st.txd     = !cfg_i.send_break; // R8
					next_st.de      = cfg_i.send_break; // R19
					if (can_send) begin
						next_st.tx_st = TX_LEAD;
						next_st.txd   = TXD_IDLE;
						next_st.de    = 1'b1; // R6 R20
					end
				end
				TX_LEAD: if (st.tx_tick == LAST_BIT_TICK) begin
					next_st.tx_st = TX_START;
					next_st.txd   = 1'b0;
					next_st.tx_shift = tx_mem[st.tx_rd]; // R11
					tx_pop = 1'b1;
				end
				TX_START: if (st.tx_tick == LAST_BIT_TICK) begin
					next_st.tx_st = TX_DATA;
					next_st.tx_bit = '0;
					next_st.txd   = st.tx_shift[0];
				end
				TX_DATA: if (st.tx_tick == LAST_BIT_TICK) begin
					next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
					next_st.tx_bit   = st.tx_bit + 1'b1;
					next_st.txd      = st.tx_shift[1];
					if (st.tx_bit == (cfg_i.eight_bits ? 3'h7 : 3'h6)) begin // R4
						next_st.tx_st = TX_STOP;
						next_st.txd   = 1'b1;
					end
				end
				TX_STOP: if (st.tx_tick == LAST_BIT_TICK) begin
					if (can_send) begin
						next_st.tx_st    = TX_START; // back to back, enable stays high
						next_st.txd      = 1'b0;
						next_st.tx_shift = tx_mem[st.tx_rd];
						tx_pop = 1'b1;
					end else begin
						next_st.tx_st = TX_IDLE;
						next_st.de    = cfg_i.send_break; // R20
						next_st.txd   = !cfg_i.send_break;
					end
				end
				default: next_st.tx_st = TX_IDLE;
			endcase
		end

		// receiver, sampled at mid bit; a zero frame with low stop bit is a break
		if (tick16) begin
			next_st.rx_tick = st.rx_tick + 1'b1;
			case (st.rx_st)
				RX_IDLE: begin
					next_st.rx_tick = '0;
					if (!rxd_i) next_st.rx_st = RX_START;
				end
				RX_START: if (st.rx_tick == HALF_BIT_TICK) begin
					next_st.rx_tick = '0;
					next_st.rx_bit  = '0;
					next_st.rx_st   = rxd_i ? RX_IDLE : RX_DATA; // glitch rejected
				end
				RX_DATA: if (st.rx_tick == LAST_BIT_TICK) begin
					next_st.rx_shift = {rxd_i, st.rx_shift[7:1]};
					next_st.rx_bit   = st.rx_bit + 1'b1;
					if (st.rx_bit == (cfg_i.eight_bits ? 3'h7 : 3'h6)) begin // R4
						next_st.rx_st = RX_STOP;
					end
				end
				RX_STOP: if (st.rx_tick == LAST_BIT_TICK) begin
					word = cfg_i.eight_bits ? st.rx_shift : {1'b0, st.rx_shift[7:1]};
					next_st.rx_st = RX_IDLE;
					if (!rxd_i) begin
						next_st.rx_st = RX_WAIT; // framing error bytes are dropped
						if (word == 8'h00) begin
							next_st.brk_flag = 1'b1; // R8 R21
							brk_set          = 1'b1;
						end
					end else if (cfg_i.flow == FLOW_XON_XOFF && word == XOFF_CHAR) begin
						next_st.xoff = 1'b1; // R7
					end else if (cfg_i.flow == FLOW_XON_XOFF && word == XON_CHAR) begin
						next_st.xoff = 1'b0; // R7
					end else begin
						rx_push = st.rx_cnt != RXC'(RX_DEPTH); // R10 R11
					end
				end
				RX_WAIT: if (rxd_i) next_st.rx_st = RX_IDLE;
				default: next_st.rx_st = RX_IDLE;
			endcase
		end
		rx_byte = word;
		if (cfg_i.flow != FLOW_XON_XOFF) next_st.xoff = 1'b0;

		// output stage; break flag travels with the next word and clears when taken
		if (!st.out_valid || rx_ready_i) begin
			next_st.out_valid = 1'b0;
			if (st.out_valid) begin
				next_st.brk_flag = brk_set || (st.brk_flag && !st.out_word.brk); // set wins
			end
			if (st.rx_cnt != '0) begin
				next_st.out_valid     = 1'b1;
				next_st.out_word.data = rx_mem[st.rx_rd];
				rx_pop = 1'b1;
			end
			next_st.out_word.brk = next_st.brk_flag; // R21
		end

		// buffer pointers and fill levels
		if (tx_push) next_st.tx_wr = st.tx_wr + 1'b1;
		if (tx_pop)  next_st.tx_rd = st.tx_rd + 1'b1;
		next_st.tx_cnt = st.tx_cnt + TXC'(tx_push) - TXC'(tx_pop);
		next_st.tx_rdy = next_st.tx_cnt != TXC'(TX_DEPTH);
		if (rx_push) next_st.rx_wr = rx_next(st.rx_wr);
		if (rx_pop)  next_st.rx_rd = rx_next(st.rx_rd);
		next_st.rx_cnt = st.rx_cnt + RXC'(rx_push) - RXC'(rx_pop);

		// flush timeout counts idle milliseconds while any word, held one included, waits
		if (rx_push || (st.rx_cnt == '0 && !st.out_valid)) begin
			next_st.ms_cnt  = '0;
			next_st.idle_ms = '0;
		end else if (st.ms_cnt == MSW'(MS_CYC - 1)) begin
			next_st.ms_cnt  = '0;
			next_st.idle_ms = st.idle_ms + 1'b1;
			if (st.idle_ms + 8'h01 >= ((cfg_i.timeout_ms == 8'h00) ? 8'h01 : cfg_i.timeout_ms)) begin
				next_st.flush   = 1'b1; // R18
				next_st.idle_ms = '0;
			end
		end else begin
			next_st.ms_cnt = st.ms_cnt + 1'b1;
		end

		// handshake outputs: low asks the peer to send
		next_st.rts_n = cfg_i.rts_n;
		next_st.dtr_n = cfg_i.dtr_n;
		if (cfg_i.flow == FLOW_RTS_CTS) begin
			next_st.rts_n = next_st.rx_cnt > RXC'(RX_DEPTH - RX_STOP_ROOM); // R7
		end
		if (cfg_i.flow == FLOW_DTR_DSR) begin
			next_st.dtr_n = next_st.rx_cnt > RXC'(RX_DEPTH - RX_STOP_ROOM); // R7
		end
		next_st.modem = modem_i; // R5

		// reset output waits for supply, oscillator and external reset together
		if (!supply_ok_i || !osc_running_i) begin
			next_st.rst_cnt   = '0;
			next_st.rst_out_n = 1'b0; // R13
		end else if (st.rst_cnt == RSW'(RST_HOLD)) begin
			next_st.rst_out_n = 1'b1; // R14
		end else begin
			next_st.rst_cnt = st.rst_cnt + 1'b1; // R14
		end
	end

	// external reset returns all control state, including the reset output, to its start
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			st <= STATE_RESET; // R13 R15
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	// buffer storage has no reset; contents are only read below the fill level
	always_ff @(posedge ref_clk_i) begin
		if (resetn_i && ce_i && tx_push) tx_mem[st.tx_wr] <= tx_data_i; // R9
		if (resetn_i && ce_i && rx_push) rx_mem[st.rx_wr] <= rx_byte; // R10
	end

	assign reset_output_n_o   = st.rst_out_n;
	assign tx_ready_o         = st.tx_rdy;
	assign rx_valid_o         = st.out_valid;
	assign rx_word_o          = st.out_word;
	assign rx_flush_o         = st.flush;
	assign txd_o              = st.txd;
	assign tx_driver_enable_o = st.de;
	assign rts_n_o            = st.rts_n;
	assign dtr_n_o            = st.dtr_n;
	assign modem_status_o     = st.modem;

endmodule : usb_serial_uart_core

`default_nettype wire

// ==== testbench/uart_core_assertions.sv ====
// Purpose: port checks on the uart core
// Assumes: one clock, ce_i high
// Notes:   low-run length only judged at prescale 0
`default_nettype none

module uart_core_checker
	import usb_uart_pkg::*;
#(
	parameter int unsigned RST_HOLD = RST_HOLD_CYCLES
) (
	// clock and reset
	input wire logic        ref_clk_i,
	input wire logic        resetn_i,
	input wire logic        ce_i,
	// reset generator
	input wire logic        supply_ok_i,
	input wire logic        osc_running_i,
	input wire logic        reset_output_n_o,
	// configuration and modem
	input wire cfg_type     cfg_i,
	input wire modem_type   modem_i,
	// receive stream
	input wire logic        rx_ready_i,
	input wire logic        rx_valid_o,
	input wire rx_word_type rx_word_o,
	input wire logic        rx_flush_o,
	// serial line
	input wire logic        txd_o,
	input wire logic        tx_driver_enable_o
);
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);

	logic [31:0] hold_cnt;
	logic [7:0]  low_run;

	// qualified reset-hold cycles, and length of each low run on txd
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i || !supply_ok_i || !osc_running_i) begin
			hold_cnt <= 32'h0;
		end else if (ce_i && hold_cnt < RST_HOLD) begin
			hold_cnt <= hold_cnt + 32'h1;
		end
		low_run <= txd_o ? 8'h00 : low_run + 8'h01;
	end

	property p_rst_low;
		disable iff (1'b0) !resetn_i || !supply_ok_i || !osc_running_i |=> !reset_output_n_o;
	endproperty
	a_rst_low: assert property (p_rst_low) else $error("reset out high");
	property p_rst_hold;
		$rose(reset_output_n_o) |-> hold_cnt >= RST_HOLD;
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("reset out early");
	property p_de_low;
		!txd_o |-> tx_driver_enable_o;
	endproperty
	a_de_low: assert property (p_de_low) else $error("line low undriven");
	property p_lead;
		$rose(tx_driver_enable_o) && txd_o |-> txd_o[*8];
	endproperty
	a_lead: assert property (p_lead) else $error("no lead bit");
	property p_rx_hold;
		rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_word_o);
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("word not held");
	property p_bit_len;
		$rose(txd_o) && cfg_i.prescale == 14'h0 |-> low_run[3:0] == 4'h0;
	endproperty
	a_bit_len: assert property (p_bit_len) else $error("bad bit length");
	property p_cts_pause;
		(cfg_i.flow == FLOW_RTS_CTS && modem_i.cts_n)[*3] |=> !$rose(tx_driver_enable_o);
	endproperty
	a_cts_pause: assert property (p_cts_pause) else $error("frame while paused");
	property p_flush;
		rx_flush_o |=> !rx_flush_o;
	endproperty
	a_flush: assert property (p_flush) else $error("flush not a pulse");

	c_brk: cover property (rx_valid_o && rx_word_o.brk);
	c_flush: cover property (rx_flush_o);
	c_rst_up: cover property ($rose(reset_output_n_o));
endmodule : uart_core_checker

bind usb_serial_uart_core uart_core_checker #(.RST_HOLD(RST_HOLD)) chk (
	.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .supply_ok_i(supply_ok_i),
	.osc_running_i(osc_running_i), .reset_output_n_o(reset_output_n_o), .cfg_i(cfg_i),
	.modem_i(modem_i), .rx_ready_i(rx_ready_i), .rx_valid_o(rx_valid_o),
	.rx_word_o(rx_word_o), .rx_flush_o(rx_flush_o), .txd_o(txd_o),
	.tx_driver_enable_o(tx_driver_enable_o));

`default_nettype wire

// ==== testbench/serial_peer.sv ====
// Purpose: serial peer across the uart line
// Assumes: bit time set in clocks
// Notes:   rxd_o is driven high while the line idles
`default_nettype none

module serial_peer (
	// clock
	input  wire logic clk_i,
	// serial line
	input  wire logic txd_i,
	output logic      rxd_o
);
	timeunit 1ns;
	timeprecision 1ns;

	int         bit_cyc = 16;
	int         nbits   = 8;
	logic [7:0] got[$];
	logic [7:0] cap;

	initial rxd_o = 1'b1;

	// one frame lsb first, then two idle bits so a break always ends high
	task automatic send(input logic [7:0] d, input logic brk);
		logic [9:0] f;
		f = brk ? 10'h000 : {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd_o = f[i];
			repeat (bit_cyc) @(negedge clk_i);
		end
		rxd_o = 1'b1;
		repeat (2 * bit_cyc) @(negedge clk_i);
	endtask : send

	// mid-bit sampling; a frame with a low stop bit is not logged
	always begin
		@(negedge txd_i);
		cap = 8'h00;
		repeat (bit_cyc / 2) @(posedge clk_i);
		for (int i = 0; i < nbits; i++) begin
			repeat (bit_cyc) @(posedge clk_i);
			cap[i] = txd_i;
		end
		repeat (bit_cyc) @(posedge clk_i);
		if (txd_i) begin
			got.push_back(cap);
		end
	end
endmodule : serial_peer

`default_nettype wire

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for the uart core
// Assumes: with every reference step taken, prescale 0 gives 16 clocks a bit
// Notes:   short ms and hold counts keep the run brief
`default_nettype none

`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
	$display("Error %0t: got %0h want %0h", $time, a, e); end end

module tb
	import usb_uart_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int unsigned MS_SIM   = 10;
	localparam int unsigned HOLD_SIM = 20;

	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        sup = 1'b1;
	logic        osc = 1'b1;
	logic        ce = 1'b1;
	logic        rtick = 1'b1;
	logic        slow = 1'b0;
	logic        tx_valid = 1'b0;
	logic        rx_ready = 1'b0;
	logic [7:0]  tx_data = 8'h00;
	cfg_type     cfg;
	modem_type   modem = 4'hf;
	logic        tx_ready, rx_valid, rx_flush, txd, rxd, de, rts_n, dtr_n, rst_out_n;
	modem_type   mstat;
	rx_word_type word;
	int          fail_count = 0;
	int          n_tests = 0;

	always #10 clk = ~clk;

	// half-rate reference steps when slow is set
	always @(negedge clk) rtick = slow ? ~rtick : 1'b1;

	usb_serial_uart_core #(.MS_CYC(MS_SIM), .RST_HOLD(HOLD_SIM)) uut (
		.ref_clk_i(clk), .resetn_i(resetn), .ce_i(ce), .ref_tick_i(rtick),
		.supply_ok_i(sup), .osc_running_i(osc), .reset_output_n_o(rst_out_n),
		.cfg_i(cfg), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
		.rx_ready_i(rx_ready), .rx_valid_o(rx_valid), .rx_word_o(word),
		.rx_flush_o(rx_flush), .txd_o(txd), .rxd_i(rxd), .tx_driver_enable_o(de),
		.rts_n_o(rts_n), .dtr_n_o(dtr_n), .modem_i(modem), .modem_status_o(mstat));
	serial_peer peer (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));

	// prescale 0 and 1 are fixed rates and ignore the fraction
	function automatic int bit_clocks(input int p, input int f);
		if (p < 2) return p ? 24 : 16;
		return 2 * (8 * p + f);
	endfunction : bit_clocks

	// offer one byte once the buffer has room
	task automatic push(input logic [7:0] d);
		int i;
		@(negedge clk);
		for (i = 0; i < 5000 && !tx_ready; i++) @(negedge clk);
		if (tx_ready !== 1'b1) fail_count++;
		tx_data = d;
		tx_valid = 1'b1;
		@(negedge clk);
		tx_valid = 1'b0;
	endtask : push

	// random stall before taking a word
	task automatic take(output rx_word_type w);
		int i;
		repeat ($urandom_range(3)) @(negedge clk);
		for (i = 0; i < 2000 && rx_valid !== 1'b1; i++) @(negedge clk);
		if (rx_valid !== 1'b1) fail_count++;
		w = word;
		rx_ready = 1'b1;
		@(negedge clk);
		rx_ready = 1'b0;
	endtask : take

	task automatic wait_got(input int n);
		for (int i = 0; i < 20000 && peer.got.size() < n; i++) @(negedge clk);
		if (peer.got.size() < n) fail_count++;
	endtask : wait_got

	task automatic results;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	// main sequence
	initial begin
		rx_word_type w;
		logic [7:0]  d;
		logic [7:0]  q[$];
		int          i;
		int          t;
		void'($urandom(55));
		cfg = '0;
		cfg.eight_bits = 1'b1;
		cfg.rts_n = 1'b1;
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		for (int k = 0; k < 2; k++) begin
			for (i = 0; i < 100 && rst_out_n !== 1'b1; i++) @(negedge clk);
			`CHK(i >= HOLD_SIM && i <= HOLD_SIM + 3, 1'b1)
			{sup, osc} = k ? 2'b01 : 2'b10;
			@(negedge clk);
			`CHK(rst_out_n, 1'b0)
			{sup, osc} = 2'b11;
		end
		$display("reset test done");
		modem = 4'($urandom);
		for (int m = 0; m < 2; m++) begin
			cfg.eight_bits = (m == 0);
			peer.nbits = m ? 7 : 8;
			q.delete();
			peer.got.delete();
			for (int j = 0; j < 12; j++) begin
				d = j == 0 ? 8'h00 : j == 1 ? 8'hff : 8'($urandom);
				q.push_back(m ? d & 8'h7f : d);
				push(d);
			end
			wait_got(12);
			foreach (q[j]) `CHK(peer.got[j], q[j])
		end
		`CHK(mstat, modem)
		`CHK({rts_n, dtr_n}, 2'b10)
		cfg.eight_bits = 1'b1;
		peer.nbits = 8;
		// first pass takes every other reference step, doubling the bit time
		for (int k = -1; k < 6; k++) begin
			slow = (k < 0);
			cfg.prescale = 14'(k < 0 ? 0 : k);
			cfg.frac = 3'($urandom);
			peer.bit_cyc = bit_clocks(k < 0 ? 0 : k, cfg.frac) * (k < 0 ? 2 : 1);
			peer.got.delete();
			d = 8'($urandom);
			push(d);
			wait_got(1);
			`CHK(peer.got[0], d)
		end
		$display("transmit test done");
		cfg.send_break = 1'b1;
		repeat (150) @(negedge clk);
		`CHK({txd, de}, 2'b01)
		cfg.send_break = 1'b0;
		repeat (200) @(negedge clk);
		`CHK({txd, de}, 2'b10)
		cfg.prescale = 14'h0;
		peer.bit_cyc = 16;
		// last three words use 7-bit frames; the peer's eighth bit then acts as stop
		for (int k = 0; k < 10; k++) begin
			cfg.eight_bits = (k < 7);
			d = k == 0 ? 8'hff : 8'($urandom);
			if (k >= 7) d[7] = 1'b1;
			if (k == 4) peer.send(8'h00, 1'b1);
			peer.send(d, 1'b0);
			take(w);
			`CHK(w, {k == 4, k < 7 ? d : d & 8'h7f})
		end
		cfg.eight_bits = 1'b1;
		for (int k = 0; k < 2; k++) begin
			cfg.timeout_ms = k ? 8'h00 : 8'h05;
			t = k ? 1 : 5;
			fork
				peer.send(8'h5a, 1'b0);
			join_none
			for (i = 0; i < 400 && rx_valid !== 1'b1; i++) @(negedge clk);
			for (i = 1; i < 400 && rx_flush !== 1'b1; i++) @(negedge clk);
			`CHK(i + 4 >= t * MS_SIM && i <= t * MS_SIM + 4, 1'b1)
			take(w);
			`CHK(w, {1'b0, 8'h5a})
			wait fork;
		end
		$display("receive test done");
		for (int k = 1; k < 4; k++) begin
			cfg.flow = flow_type'(k);
			modem = 4'hf;
			peer.got.delete();
			if (k == 3) peer.send(XOFF_CHAR, 1'b0);
			d = 8'($urandom);
			push(d);
			repeat (300) @(negedge clk);
			`CHK(peer.got.size(), 0)
			`CHK({rts_n, dtr_n}, k == 1 ? 2'b00 : 2'b10)
			modem = 4'h0;
			if (k == 3) peer.send(XON_CHAR, 1'b0);
			wait_got(1);
			`CHK(peer.got[0], d)
			`CHK(rx_valid, 1'b0)
		end
		// a low enable freezes everything, so an offer made then is never stored
		repeat (20) @(negedge clk);
		ce = 1'b0;
		peer.got.delete();
		push(8'h3c);
		repeat (200) @(negedge clk);
		`CHK({txd, de, tx_ready}, 3'b101)
		ce = 1'b1;
		repeat (400) @(negedge clk);
		`CHK(peer.got.size(), 0)
		$display("flow test done");
		results();
	end

	// cut a hang short well past the expected run
	initial begin
		repeat (80000) @(posedge clk);
		fail_count++;
		results();
	end
endmodule : tb

`default_nettype wire
